// ### design/serial_link_param_status_regs.sv
// identifier, frame-end comma and status registers of a serial transmit link
//
// Behaviour
// - the identifier register value is sent in the second multiframe of lane alignment.
// - comma select 0/1/2 picks K28.7/K28.1/K28.5 as end-of-frame, 3 is reserved.
// - the comma replaces frame-end data only when the encoder says it may.
// - comma select sets eof_comma in every mode; the comma is inserted in 8B/10B mode only, never in 64B/66B mode.
// - status bit 6 reads 1 while the link is up.
// - status bit 5 reads the sync level: 0 asserted, 1 released.
// - status bit 4 sets on a sysref phase shift and holds until a 1 is written.
// - status bit 3 sets on the first sysref after enable and clears on a written 1.
// - status bit 2 reads the serializer pll lock.
// - status bit 0 reads the sampling pll lock.
`include "serial_link_params.svh"

module serial_link_param_status_regs #(
    parameter int ADDR_W = 12
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclken,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // asynchronous pins
    input wire logic sync_n,
    input wire logic serializer_pll_lock,
    input wire logic sampling_pll_lock,
    // link encoder, same clock
    input wire logic link_up,
    input wire logic sysref_event,
    input wire logic sysref_phase_shift,
    input wire logic frame_end,
    input wire logic frame_end_insert_ok,
    input wire logic ila_active,
    input wire serial_link_pkg::ila_mf_t ila_mf,
    // to the link encoder
    output logic link_enable,
    output logic mode_64b66b,
    output serial_link_pkg::reg_byte_t ila_did,
    output logic ila_did_valid,
    output serial_link_pkg::reg_byte_t eof_comma,
    output logic eof_comma_insert,
    // interrupt
    output logic irq
);

    serial_link_pkg::reg_byte_t ident;
    serial_link_pkg::reg_byte_t comma_sel;
    serial_link_pkg::reg_byte_t mask;
    logic realigned;
    logic lmfc_phase_set_flag;
    logic align_armed;
    logic enable_q;
    logic [2:0] sync_meta;
    logic [2:0] sync_s;
    logic acc;
    logic wr_go;
    logic [9:0] idx;
    logic hit_ident, hit_comma, hit_status, hit_mask, hit_ctrl;
    serial_link_pkg::reg_byte_t status;
    serial_link_pkg::reg_byte_t next_rdata;
    serial_link_pkg::reg_byte_t next_comma;
    logic [1:0] sticky;

    // decode; word index is the address without its byte lanes
    // only the index is compared, so a byte offset inside a word aliases that word
    assign idx = paddr[11:2];
    assign hit_ident = idx == `SLR_IDENT_IDX;
    assign hit_comma = idx == `SLR_COMMA_IDX;
    assign hit_status = idx == `SLR_STATUS_IDX;
    assign hit_mask = idx == `SLR_IRQ_MASK_IDX;
    assign hit_ctrl = idx == `SLR_CTRL_IDX;
    assign acc = pclken && psel && penable && !pready;
    assign wr_go = pclken && psel && penable && pready && pwrite;

    // two-flop synchronisers for the pins; nothing reads the first stage
    // stages reset low, so a lock or a released sync reads 0 for two edges after reset
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync_meta[g] <= 1'b0;
                    sync_s[g] <= 1'b0;
                end else if (pclken) begin
                    sync_meta[g] <= (g == 0) ? sync_n :
                        (g == 1) ? serializer_pll_lock : sampling_pll_lock;
                    sync_s[g] <= sync_meta[g];
                end
            end
        end
    endgenerate

    // status view; reserved bits tied low, live bits straight from state
    always_comb begin
        status = 8'h00;
        status[`SLR_ST_LINK_UP] = link_up;
        status[`SLR_ST_SYNC] = sync_s[0];
        status[`SLR_ST_REALIGNED] = realigned;
        status[`SLR_ST_LMFC_PHASE_SET_FLAG] = lmfc_phase_set_flag;
        status[`SLR_ST_SPLL] = sync_s[1];
        status[`SLR_ST_CPLL] = sync_s[2];
    end

    // read mux
    always_comb begin
        next_rdata = 8'h00;
        if (hit_ident) begin
            next_rdata = ident;
        end else if (hit_comma) begin
            next_rdata = comma_sel;
        end else if (hit_status) begin
            next_rdata = status;
        end else if (hit_mask) begin
            next_rdata = mask;
        end else if (hit_ctrl) begin
            next_rdata = {6'h00, mode_64b66b, link_enable};
        end
    end

    // apb answer: one wait state, then pready for a single cycle
    // pready only moves on enabled edges, so pclken low stretches the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (pclken) begin
            pready <= acc;
            if (acc) begin
                prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, next_rdata};
                pslverr <= !(hit_ident || hit_comma || hit_status || hit_mask || hit_ctrl);
            end
        end
    end

    // configuration registers; written whole, upper comma bits kept as written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ident <= `SLR_IDENT_RST;
            comma_sel <= `SLR_COMMA_RST;
            mask <= `SLR_MASK_RST;
            link_enable <= 1'b0;
            mode_64b66b <= 1'b0;
        end else if (wr_go) begin
            if (hit_ident) begin
                ident <= pwdata[7:0];
            end
            if (hit_comma) begin
                comma_sel <= pwdata[7:0];
            end
            if (hit_mask) begin
                mask <= pwdata[7:0];
            end
            if (hit_ctrl) begin
                link_enable <= pwdata[`SLR_CTL_ENABLE];
                mode_64b66b <= pwdata[`SLR_CTL_64B66B];
            end
        end
    end

    // enable edge arms the lmfc phase flag for the next sysref
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q <= 1'b0;
            align_armed <= 1'b0;
        end else if (pclken) begin
            enable_q <= link_enable;
            if (link_enable && !enable_q) begin
                align_armed <= 1'b1;
            end else if (sysref_event || !link_enable) begin
                align_armed <= 1'b0;
            end
        end
    end

    // sticky flags: an event in the clearing cycle wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            realigned <= 1'b0;
            lmfc_phase_set_flag <= 1'b0;
        end else if (pclken) begin
            if (sysref_phase_shift) begin
                realigned <= 1'b1;
            end else if (wr_go && hit_status && pwdata[`SLR_ST_REALIGNED]) begin
                realigned <= 1'b0;
            end
            if (sysref_event && align_armed) begin
                lmfc_phase_set_flag <= 1'b1;
            end else if (wr_go && hit_status && pwdata[`SLR_ST_LMFC_PHASE_SET_FLAG]) begin
                lmfc_phase_set_flag <= 1'b0;
            end
        end
    end

    // comma character lookup; reserved code falls back to the default
    always_comb begin
        unique case (comma_sel[1:0])
            `SLR_SEL_K28_1: next_comma = `SLR_K28_1;
            `SLR_SEL_K28_5: next_comma = `SLR_K28_5;
            default: next_comma = `SLR_K28_7;
        endcase
    end

    // link-side outputs, all registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ila_did <= 8'h00;
            ila_did_valid <= 1'b0;
            eof_comma <= `SLR_K28_7;
            eof_comma_insert <= 1'b0;
        end else if (pclken) begin
            ila_did_valid <= link_enable && ila_active && ila_mf == `SLR_ILA_DID_MF;
            ila_did <= ident;
            eof_comma <= next_comma;
            // only where the encoder has room, and never in 64b66b
            eof_comma_insert <= link_enable && !mode_64b66b &&
                frame_end && frame_end_insert_ok;
        end
    end

    // level interrupt from unmasked sticky flags
    assign sticky = {realigned, lmfc_phase_set_flag};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else if (pclken) begin
            irq <= |(sticky & {mask[`SLR_ST_REALIGNED], mask[`SLR_ST_LMFC_PHASE_SET_FLAG]});
        end
    end

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ila_did_out_a: assert property (
        pclken && link_enable && ila_active && ila_mf == `SLR_ILA_DID_MF
        |=> ila_did_valid && ila_did == $past(ident))
        else $error("identifier not sent in second multiframe");

    comma_map_a: assert property (
        pclken && comma_sel[1:0] == `SLR_SEL_K28_5 |=> eof_comma == `SLR_K28_5)
        else $error("comma select code 2 did not give K28.5");

    comma_chance_a: assert property (
        $past(pclken) && eof_comma_insert |-> $past(frame_end && frame_end_insert_ok))
        else $error("comma inserted without an opening");

    comma_mode_a: assert property (
        pclken && mode_64b66b |=> !eof_comma_insert)
        else $error("comma inserted in 64b66b mode");

    link_up_read_a: assert property (
        acc && !pwrite && hit_status |=> pready && prdata[6] == $past(link_up)
            && prdata[7] == 1'b0 && prdata[1] == 1'b0)
        else $error("status read shows wrong link state");

    sync_chain_a: assert property (
        pclken && $past(pclken) && $past(pclken, 2) && $past(presetn) && $past(presetn, 2)
        |-> sync_s[0] == $past(sync_n, 2))
        else $error("sync level not two stages late");

    realign_set_a: assert property (
        pclken && sysref_phase_shift |=> realigned [*2])
        else $error("realign flag not set or not held");

    lmfc_phase_set_flag_first_a: assert property (
        $rose(lmfc_phase_set_flag) |-> $past(sysref_event && align_armed))
        else $error("lmfc flag set without first sysref");

    w1c_clear_a: assert property (
        wr_go && hit_status && pwdata[4] && !sysref_phase_shift |=> !realigned)
        else $error("write one did not clear realign flag");

    irq_level_a: assert property (
        pclken |=> irq == $past(|(sticky & {mask[4], mask[3]})))
        else $error("interrupt does not follow masked flags");

    // pll lock status bits lag their pins by exactly the two synchroniser stages
    lock_chain_a: assert property (
        $past(pclken) && $past(pclken, 2) && $past(presetn) && $past(presetn, 2)
        |-> sync_s[1] == $past(serializer_pll_lock, 2)
            && sync_s[2] == $past(sampling_pll_lock, 2))
        else $error("pll lock not two stages late");

    sync_read_a: assert property (
        acc && !pwrite && hit_status |=> prdata[5] == $past(sync_s[0]))
        else $error("status read shows wrong sync level");

    pll_read_a: assert property (
        acc && !pwrite && hit_status
        |=> prdata[2] == $past(sync_s[1]) && prdata[0] == $past(sync_s[2]))
        else $error("status read shows wrong pll lock");

    comma_dflt_a: assert property (
        pclken && (comma_sel[1:0] == `SLR_SEL_K28_7 || comma_sel[1:0] == 2'h3)
        |=> eof_comma == `SLR_K28_7)
        else $error("comma select code 0 or 3 did not give K28.7");

    comma_alt_a: assert property (
        pclken && comma_sel[1:0] == `SLR_SEL_K28_1 |=> eof_comma == `SLR_K28_1)
        else $error("comma select code 1 did not give K28.1");

    ila_quiet_a: assert property (
        pclken && !(link_enable && ila_active && ila_mf == `SLR_ILA_DID_MF) |=> !ila_did_valid)
        else $error("identifier flagged outside second multiframe");

    align_clear_a: assert property (
        wr_go && hit_status && pwdata[3] && !(sysref_event && align_armed) |=> !lmfc_phase_set_flag)
        else $error("write one did not clear lmfc flag");

    // clock enable low must leave every flag and every answer where it was
    freeze_hold_a: assert property (
        !pclken |=> $stable(realigned) && $stable(lmfc_phase_set_flag) && $stable(irq)
            && $stable(pready) && $stable(ident) && $stable(link_enable))
        else $error("state moved while the clock enable was low");

    ready_pulse_a: assert property (
        pclken && pready |=> !pready)
        else $error("apb answer stood longer than one cycle");

    status_wr_c: cover property (wr_go && hit_status && pwdata[3]);
    did_send_c: cover property (ila_did_valid);
    comma_ins_c: cover property (eof_comma_insert && eof_comma == `SLR_K28_1);
    err_c: cover property (pready && pslverr);
    freeze_c: cover property (!pclken && sysref_phase_shift);

endmodule : serial_link_param_status_regs

// ### design/serial_link_params.svh
// offsets, field positions, reset values and codes of the serial link register slice
`ifndef SERIAL_LINK_PARAMS_SVH
`define SERIAL_LINK_PARAMS_SVH

// register indices; byte address is four times the index
`define SLR_IDENT_IDX 10'h206
`define SLR_COMMA_IDX 10'h207
`define SLR_STATUS_IDX 10'h208
`define SLR_IRQ_MASK_IDX 10'h280
`define SLR_CTRL_IDX 10'h281
`define SLR_ADDR(idx) {(idx), 2'b00}

// reset values
`define SLR_IDENT_RST 8'h00
`define SLR_COMMA_RST 8'h00
`define SLR_MASK_RST 8'h00
`define SLR_CTRL_RST 8'h00

// status field positions
`define SLR_ST_LINK_UP 6
`define SLR_ST_SYNC 5
`define SLR_ST_REALIGNED 4
`define SLR_ST_LMFC_PHASE_SET_FLAG 3
`define SLR_ST_SPLL 2
`define SLR_ST_CPLL 0

// control field positions
`define SLR_CTL_ENABLE 0
`define SLR_CTL_64B66B 1

// comma select codes and the control characters they pick
`define SLR_SEL_K28_7 2'h0
`define SLR_SEL_K28_1 2'h1
`define SLR_SEL_K28_5 2'h2
`define SLR_K28_7 8'hfc
`define SLR_K28_1 8'h3c
`define SLR_K28_5 8'hbc

// initial lane alignment multiframe that carries the identifier
`define SLR_ILA_DID_MF 2'h1
`define SLR_SYNC_STAGES 2

`endif

// ### design/serial_link_pkg.sv
// shared types of the serial link register slice
package serial_link_pkg;
    typedef logic [7:0] reg_byte_t;
    typedef logic [1:0] comma_sel_t;
    typedef logic [1:0] ila_mf_t;
endpackage : serial_link_pkg

// ### test/link_far_model.sv
// far side model: pins and link encoder strobes seen by the register slice
module link_far_model (
    // clock
    input wire logic pclk,
    // asynchronous pins
    output logic sync_n,
    output logic ser_lock,
    output logic smp_lock,
    // encoder strobes and levels
    output logic link_up,
    output logic sysref_event,
    output logic phase_shift,
    output logic frame_end,
    output logic insert_ok,
    output logic ila_active,
    output serial_link_pkg::ila_mf_t ila_mf
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle: locks low, sync released, no strobes
    initial begin
        {link_up, ser_lock, smp_lock, sysref_event, phase_shift} = 5'h00;
        {frame_end, insert_ok, ila_active, ila_mf} = 5'h00;
        sync_n = 1'b1;
    end

    // levels change just after an edge, as real pins would
    task automatic set_levels(input logic [3:0] v);
        @(posedge pclk);
        {link_up, sync_n, ser_lock, smp_lock} <= v;
    endtask : set_levels

    // lane alignment phase and multiframe index
    task automatic set_ila(input logic act, input logic [1:0] mf);
        @(posedge pclk);
        ila_active <= act;
        ila_mf <= mf;
    endtask : set_ila

    // one-cycle strobe: 0 sysref, 1 phase shift, 2 frame end with permission ok
    task automatic pulse(input int k, input logic ok);
        @(posedge pclk);
        sysref_event <= (k == 0);
        phase_shift <= (k == 1);
        frame_end <= (k == 2);
        insert_ok <= ok;
        @(posedge pclk);
        {sysref_event, phase_shift, frame_end, insert_ok} <= 4'h0;
    endtask : pulse
endmodule : link_far_model

// ### test/serial_link_param_status_regs_test.sv
// self-checking bench of the serial link register slice
`include "serial_link_params.svh"
module serial_link_param_status_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic pclken = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, sync_n, ser_lock, smp_lock, link_up, sysref_event, phase_shift;
    logic frame_end, insert_ok, ila_active, link_enable, mode_64b66b, ila_did_valid;
    logic eof_comma_insert, irq;
    serial_link_pkg::ila_mf_t ila_mf;
    serial_link_pkg::reg_byte_t ila_did, eof_comma;
    logic [32:0] exp_q[$];
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;

    serial_link_param_status_regs i_dut (.pclk(pclk), .presetn(presetn), .pclken(pclken),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_n(sync_n),
        .serializer_pll_lock(ser_lock), .sampling_pll_lock(smp_lock), .link_up(link_up),
        .sysref_event(sysref_event), .sysref_phase_shift(phase_shift), .frame_end(frame_end),
        .frame_end_insert_ok(insert_ok), .ila_active(ila_active), .ila_mf(ila_mf),
        .link_enable(link_enable), .mode_64b66b(mode_64b66b), .ila_did(ila_did),
        .ila_did_valid(ila_did_valid), .eof_comma(eof_comma),
        .eof_comma_insert(eof_comma_insert), .irq(irq));
    link_far_model i_far (.pclk(pclk), .sync_n(sync_n), .ser_lock(ser_lock),
        .smp_lock(smp_lock), .link_up(link_up), .sysref_event(sysref_event),
        .phase_shift(phase_shift), .frame_end(frame_end), .insert_ok(insert_ok),
        .ila_active(ila_active), .ila_mf(ila_mf));

    always #2 pclk = ~pclk;

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // a hang counts as a mismatch
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            stop_test();
        end
    end

    // read answers taken at the edge that samples pready, against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
            check({pslverr, prdata}, exp_q.pop_front());
        end
    end

    // apb cycle: setup, access held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        @(posedge pclk);
        if (!wr) exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // hold everything until pready is seen high at a rising edge
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask : rd

    // status image from pin levels {up, sync, ser, smp} and flags {realigned, lmfc_phase_set_flag}
    function automatic logic [31:0] st(input logic [3:0] v, input logic [1:0] f);
        return {24'h0, 1'b0, v[3], v[2], f, v[1], 1'b0, v[0]};
    endfunction : st

    function automatic logic [7:0] comma_of(input int c);
        return (c == 1) ? `SLR_K28_1 : (c == 2) ? `SLR_K28_5 : `SLR_K28_7;
    endfunction : comma_of

    initial begin
        logic [7:0] id_val;
        logic [3:0] lv;
        void'($urandom(32'h1f18b117));
        id_val = 8'($urandom);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, then an unmapped read
        rd(`SLR_ADDR(`SLR_IDENT_IDX), 32'h0);
        rd(`SLR_ADDR(`SLR_COMMA_IDX), 32'h0);
        // sync idles released, so its bit reads 1 once it has crossed the synchroniser
        rd(`SLR_ADDR(`SLR_STATUS_IDX), st(4'h4, 2'h0));
        rd(`SLR_ADDR(`SLR_IRQ_MASK_IDX), 32'h0);
        rd(`SLR_ADDR(`SLR_CTRL_IDX), 32'h0);
        apb(1'b0, 12'h7fc, 32'h0, 33'h100000000);
        check(33'(eof_comma), 33'(`SLR_K28_7));
        $display("test reset done");
        // identifier and every comma code, written while the link is off
        wr(`SLR_ADDR(`SLR_IDENT_IDX), {24'h0, id_val});
        rd(`SLR_ADDR(`SLR_IDENT_IDX), {24'h0, id_val});
        for (int c = 0; c < 4; c++) begin
            wr(`SLR_ADDR(`SLR_COMMA_IDX), 32'(c));
            @(posedge pclk);
            #1 check(33'(eof_comma), 33'(comma_of(c)));
        end
        wr(`SLR_ADDR(`SLR_COMMA_IDX), 32'h0);
        $display("test codes done");
        // pin bits pass the synchroniser, link up follows directly, and all ignore writes
        for (int k = 0; k < 3; k++) begin
            lv = 4'($urandom);
            i_far.set_levels(lv);
            repeat (4) @(posedge pclk);
            rd(`SLR_ADDR(`SLR_STATUS_IDX), st(lv, 2'h0));
            wr(`SLR_ADDR(`SLR_STATUS_IDX), 32'hff);
            rd(`SLR_ADDR(`SLR_STATUS_IDX), st(lv, 2'h0));
        end
        $display("test live done");
        // sticky flags, interrupt raise, clear and mask
        wr(`SLR_ADDR(`SLR_IRQ_MASK_IDX), 32'h18);
        wr(`SLR_ADDR(`SLR_CTRL_IDX), 32'h1);
        #1 check(33'({mode_64b66b, link_enable}), 33'h1);
        i_far.pulse(0, 1'b0);
        @(posedge pclk);
        #1 check(33'(irq), 33'h1);
        i_far.pulse(1, 1'b0);
        rd(`SLR_ADDR(`SLR_STATUS_IDX), st(lv, 2'h3));
        wr(`SLR_ADDR(`SLR_STATUS_IDX), 32'h10);
        rd(`SLR_ADDR(`SLR_STATUS_IDX), st(lv, 2'h1));
        wr(`SLR_ADDR(`SLR_STATUS_IDX), 32'h08);
        i_far.pulse(0, 1'b0);
        rd(`SLR_ADDR(`SLR_STATUS_IDX), st(lv, 2'h0));
        check(33'(irq), 33'h0);
        wr(`SLR_ADDR(`SLR_IRQ_MASK_IDX), 32'h08);
        i_far.pulse(1, 1'b0);
        repeat (2) @(posedge pclk);
        #1 check(33'(irq), 33'h0);
        wr(`SLR_ADDR(`SLR_STATUS_IDX), 32'h10);
        // a phase shift while the clock enable is low must leave no trace
        @(posedge pclk);
        pclken <= 1'b0;
        i_far.pulse(1, 1'b0);
        @(posedge pclk);
        pclken <= 1'b1;
        rd(`SLR_ADDR(`SLR_STATUS_IDX), st(lv, 2'h0));
        $display("test flags done");
        // identifier in the second multiframe only
        i_far.set_ila(1'b1, `SLR_ILA_DID_MF);
        @(posedge pclk);
        #1 check({ila_did_valid, ila_did}, {1'b1, id_val});
        i_far.set_ila(1'b1, 2'h0);
        @(posedge pclk);
        #1 check(33'(ila_did_valid), 33'h0);
        i_far.set_ila(1'b0, 2'h0);
        // comma inserted only when permitted and only in 8b/10b
        for (int k = 0; k < 3; k++) begin
            if (k == 2) begin
                wr(`SLR_ADDR(`SLR_CTRL_IDX), 32'h3);
                rd(`SLR_ADDR(`SLR_CTRL_IDX), 32'h3);
            end
            i_far.pulse(2, k != 0);
            #1 check(33'(eof_comma_insert), 33'(k == 1));
        end
        $display("test link done");
        stop_test();
    end
endmodule : serial_link_param_status_regs_test
